/* File: common/midi_host_port_pkg.sv */
// shared constants and types for the host-facing midi port
package midi_host_port_pkg;

    localparam int          CLK_PERIOD_PS     = 5000;
    localparam int          BIT_TIME_NS       = 32000;
    localparam int          BIT_CYCLES        = (BIT_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int          FIFO_DEPTH        = 16;
    localparam int          PTR_W             = 4;
    localparam int          CNT_W             = 5;
    localparam logic [4:0]  FIFO_FULL         = 5'h10;
    localparam int          STAT_EMPTY_BIT    = 7;
    localparam int          STAT_BUSY_BIT     = 6;
    localparam logic [7:0]  STATUS_RESET      = 8'h80;
    localparam logic [7:0]  CMD_RESET         = 8'hff;
    localparam logic [7:0]  CMD_PASS          = 8'h3f;
    localparam logic [7:0]  ACK_BYTE          = 8'hfe;
    localparam logic [15:0] DATA_OFS          = 16'h0000;
    localparam logic [15:0] STAT_OFS          = 16'h0001;
    localparam logic [7:0]  CFG_ACTIVATE_IDX  = 8'h30;
    localparam logic [7:0]  CFG_BASE_HIGH_IDX = 8'h60;
    localparam logic [7:0]  CFG_BASE_LOW_IDX  = 8'h61;
    localparam int          ACTIVATE_BIT      = 0;
    localparam logic [7:0]  BASE_HIGH_RESET   = 8'h03;
    localparam logic [7:0]  BASE_LOW_RESET    = 8'h30;

    typedef enum logic {
        MODE_RESET,
        MODE_PASS
    } mode_e;

endpackage

/* File: hdl/midi_serial_engine.sv */
// full-duplex 8n1 serial shift engine, one frame at a time each way
`timescale 1ns/1ps
module midi_serial_engine
    import midi_host_port_pkg::*;
#(
    parameter int BIT_CYCLES_P = BIT_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_enable,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready,
    output logic            o_serial_out,
    input  wire logic       i_serial_in,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data
);

    localparam logic [15:0] LAST_CNT = 16'(BIT_CYCLES_P - 1);
    localparam logic [15:0] HALF_CNT = 16'(BIT_CYCLES_P / 2 - 1);

    logic        tx_busy_ff, nxt_tx_busy;
    logic [9:0]  tx_shift_ff, nxt_tx_shift;
    logic [15:0] tx_cnt_ff, nxt_tx_cnt;
    logic [3:0]  tx_bits_ff, nxt_tx_bits;

    logic        sync1_ff, sync2_ff;
    logic        rx_busy_ff, nxt_rx_busy;
    logic [15:0] rx_cnt_ff, nxt_rx_cnt;
    logic [3:0]  rx_bits_ff, nxt_rx_bits;
    logic [7:0]  rx_shift_ff, nxt_rx_shift;
    logic        rx_valid_ff, nxt_rx_valid;
    logic [7:0]  rx_data_ff, nxt_rx_data;

    assign o_tx_ready   = !tx_busy_ff;
    assign o_serial_out = tx_shift_ff[0];
    assign o_rx_valid   = rx_valid_ff;
    assign o_rx_data    = rx_data_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // transmit: start bit, eight data bits lsb first, stop bit
    always_comb begin
        nxt_tx_busy  = tx_busy_ff;
        nxt_tx_shift = tx_shift_ff;
        nxt_tx_cnt   = tx_cnt_ff;
        nxt_tx_bits  = tx_bits_ff;
        if (!i_enable) begin
            nxt_tx_busy  = 1'b0;
            nxt_tx_shift = 10'h3ff;
        end else if (!tx_busy_ff) begin
            if (i_tx_valid) begin
                nxt_tx_busy  = 1'b1;
                nxt_tx_shift = {1'b1, i_tx_data, 1'b0};
                nxt_tx_cnt   = 16'h0000;
                nxt_tx_bits  = 4'h0;
            end
        end else if (tx_cnt_ff == LAST_CNT) begin
            nxt_tx_cnt   = 16'h0000;
            nxt_tx_shift = {1'b1, tx_shift_ff[9:1]};
            if (tx_bits_ff == 4'h9) begin
                nxt_tx_busy = 1'b0;
            end else begin
                nxt_tx_bits = tx_bits_ff + 4'h1;
            end
        end else begin
            nxt_tx_cnt = tx_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_busy_ff  <= 1'b0;
            tx_shift_ff <= 10'h3ff;
            tx_cnt_ff   <= 16'h0000;
            tx_bits_ff  <= 4'h0;
        end else begin
            tx_busy_ff  <= nxt_tx_busy;
            tx_shift_ff <= nxt_tx_shift;
            tx_cnt_ff   <= nxt_tx_cnt;
            tx_bits_ff  <= nxt_tx_bits;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive: sample mid-bit, drop frames with a bad stop bit
    always_comb begin
        nxt_rx_busy  = rx_busy_ff;
        nxt_rx_cnt   = rx_cnt_ff;
        nxt_rx_bits  = rx_bits_ff;
        nxt_rx_shift = rx_shift_ff;
        nxt_rx_valid = 1'b0;
        nxt_rx_data  = rx_data_ff;
        if (!i_enable) begin
            nxt_rx_busy = 1'b0;
        end else if (!rx_busy_ff) begin
            if (!sync2_ff) begin
                nxt_rx_busy = 1'b1;
                nxt_rx_cnt  = 16'h0000;
                nxt_rx_bits = 4'h0;
            end
        end else if (rx_cnt_ff == ((rx_bits_ff == 4'h0) ? HALF_CNT : LAST_CNT)) begin
            nxt_rx_cnt = 16'h0000;
            if (rx_bits_ff == 4'h0) begin
                if (sync2_ff) begin
                    nxt_rx_busy = 1'b0;
                end else begin
                    nxt_rx_bits = 4'h1;
                end
            end else if (rx_bits_ff != 4'h9) begin
                nxt_rx_shift = {sync2_ff, rx_shift_ff[7:1]};
                nxt_rx_bits  = rx_bits_ff + 4'h1;
            end else begin
                nxt_rx_busy = 1'b0;
                if (sync2_ff) begin
                    nxt_rx_valid = 1'b1;
                    nxt_rx_data  = rx_shift_ff;
                end
            end
        end else begin
            nxt_rx_cnt = rx_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_ff    <= 1'b1;
            sync2_ff    <= 1'b1;
            rx_busy_ff  <= 1'b0;
            rx_cnt_ff   <= 16'h0000;
            rx_bits_ff  <= 4'h0;
            rx_shift_ff <= 8'h00;
            rx_valid_ff <= 1'b0;
            rx_data_ff  <= 8'h00;
        end else begin
            sync1_ff    <= i_serial_in;
            sync2_ff    <= sync1_ff;
            rx_busy_ff  <= nxt_rx_busy;
            rx_cnt_ff   <= nxt_rx_cnt;
            rx_bits_ff  <= nxt_rx_bits;
            rx_shift_ff <= nxt_rx_shift;
            rx_valid_ff <= nxt_rx_valid;
            rx_data_ff  <= nxt_rx_data;
        end
    end

endmodule

/* File: hdl/midi_host_port_uart.sv */
// host-facing midi port: data/status/command ports, command controller, fifos
//
// Overview of operation
// - status port is read-only; bit 7 receive-empty, bit 6 transmit-busy.
// - receive-empty reads 0 while a byte or acknowledge waits, else 1.
// - interrupt is high exactly when activate is 1 and receive-empty is 0.
// - transmit-busy reads 0 when another data or command byte can be taken; here it reads 1 only while the 16-byte transmit fifo is full.
// - no interrupt for transmit activity or transmit readiness.
// - status bits 5..0 ignore writes and read as zero.
// - a write to base plus one is a command byte.
// - a data read drops the interrupt unless more receive bytes remain.
// - interrupt ignores write data, transmit functions and line status.
// - only commands ffh and 3fh act; all others are ignored.
// - ffh leaves pass-through, stops engine, flushes rx; ack only if not passing.
// - ffh in pass-through still resets but queues no acknowledge.
// - in reset state serial input and host data writes are discarded.
// - reset state is entered after power-on and after the reset command.
// - 3fh outside pass-through flushes both fifos, queues feh, enables engine.
// - in pass-through data passes unmodified both ways.
// - 3fh while already in pass-through does nothing and gives no acknowledge.
// - acknowledge is the next byte read, placed after the rx flush.
// - frames are 31.25 kbd, start, eight data lsb first, no parity, one stop.
// - engine is full duplex with 16-byte transmit and receive fifos.
// - activate 0 disables decode, holds interrupt low, idles logic.
// - data port at base is read/write, full duplex.
`timescale 1ns/1ps
module midi_host_port_uart
    import midi_host_port_pkg::*;
#(
    parameter int BIT_CYCLES_P = BIT_CYCLES
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    input  wire logic [15:0] I_IO_ADDR,
    input  wire logic        I_IO_WR,
    input  wire logic        I_IO_RD,
    input  wire logic [7:0]  I_IO_WDATA,
    output logic [7:0]       O_IO_RDATA,
    output logic             O_IO_RVALID,
    input  wire logic        I_CFG_WR,
    input  wire logic        I_CFG_RD,
    input  wire logic [7:0]  I_CFG_IDX,
    input  wire logic [7:0]  I_CFG_WDATA,
    output logic [7:0]       O_CFG_RDATA,
    output logic             O_IRQ,
    input  wire logic        I_SERIAL_IN_LINE,
    output logic             O_SERIAL_OUT
);

    mode_e            mode_ff, nxt_mode;
    logic             ack_ff, nxt_ack;
    logic             active_ff, nxt_active;
    logic [7:0]       base_hi_ff, nxt_base_hi;
    logic [7:0]       base_lo_ff, nxt_base_lo;
    logic [7:0]       rdata_ff, nxt_rdata;
    logic             rvalid_ff, nxt_rvalid;
    logic [7:0]       cfg_rdata_ff, nxt_cfg_rdata;
    logic [7:0]       rx_mem [FIFO_DEPTH];
    logic [7:0]       tx_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] rx_wp_ff, rx_rp_ff, tx_wp_ff, tx_rp_ff;
    logic [PTR_W-1:0] nxt_rx_wp, nxt_rx_rp, nxt_tx_wp, nxt_tx_rp;
    logic [CNT_W-1:0] rx_cnt_ff, tx_cnt_ff, nxt_rx_cnt, nxt_tx_cnt;
    logic             rx_push, rx_pop, tx_push, tx_pop, rx_flush, tx_flush;
    logic             rx_buffer_empty_flag, serial_tx_busy_flag;
    logic             eng_enable, eng_tx_ready, eng_rx_valid;
    logic [7:0]       eng_rx_data;
    logic [15:0]      base_addr;
    logic             hit_data, hit_stat;

    ////////////////////////////////////////////////////////////////////////////////
    // flags, decode, interrupt
    assign rx_buffer_empty_flag = !ack_ff && (rx_cnt_ff == '0);
    assign serial_tx_busy_flag  = (tx_cnt_ff == FIFO_FULL);
    assign O_IRQ      = active_ff && !rx_buffer_empty_flag;
    assign base_addr  = {base_hi_ff, base_lo_ff[7:1], 1'b0};
    assign eng_enable = active_ff && (mode_ff == MODE_PASS);
    assign O_IO_RDATA  = rdata_ff;
    assign O_IO_RVALID = rvalid_ff;
    assign O_CFG_RDATA = cfg_rdata_ff;

    always_comb begin
        hit_data = 1'b0;
        hit_stat = 1'b0;
        if (!active_ff) begin
            hit_data = 1'b0;
        end else if (I_IO_ADDR == base_addr + DATA_OFS) begin
            hit_data = 1'b1;
        end else if (I_IO_ADDR == base_addr + STAT_OFS) begin
            hit_stat = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command controller, port access, fifo pointers
    always_comb begin
        nxt_mode      = mode_ff;
        nxt_ack       = ack_ff;
        nxt_active    = active_ff;
        nxt_base_hi   = base_hi_ff;
        nxt_base_lo   = base_lo_ff;
        nxt_rdata     = rdata_ff;
        nxt_rvalid    = 1'b0;
        nxt_cfg_rdata = cfg_rdata_ff;
        rx_pop        = 1'b0;
        tx_push       = 1'b0;
        rx_flush      = 1'b0;
        tx_flush      = 1'b0;
        if (I_CFG_WR) begin
            if (I_CFG_IDX == CFG_ACTIVATE_IDX) begin
                nxt_active = I_CFG_WDATA[ACTIVATE_BIT];
            end else if (I_CFG_IDX == CFG_BASE_HIGH_IDX) begin
                nxt_base_hi = I_CFG_WDATA;
            end else if (I_CFG_IDX == CFG_BASE_LOW_IDX) begin
                nxt_base_lo = I_CFG_WDATA;
            end
        end
        if (I_CFG_RD) begin
            if (I_CFG_IDX == CFG_ACTIVATE_IDX) begin
                nxt_cfg_rdata = {7'h00, active_ff};
            end else if (I_CFG_IDX == CFG_BASE_HIGH_IDX) begin
                nxt_cfg_rdata = base_hi_ff;
            end else if (I_CFG_IDX == CFG_BASE_LOW_IDX) begin
                nxt_cfg_rdata = base_lo_ff;
            end else begin
                nxt_cfg_rdata = 8'h00;
            end
        end
        if (I_IO_RD && hit_data) begin
            nxt_rvalid = 1'b1;
            if (ack_ff) begin
                nxt_rdata = ACK_BYTE;
                nxt_ack   = 1'b0;
            end else if (rx_cnt_ff != '0) begin
                nxt_rdata = rx_mem[rx_rp_ff];
                rx_pop    = 1'b1;
            end
        end else if (I_IO_RD && hit_stat) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = {rx_buffer_empty_flag, serial_tx_busy_flag, 6'h00};
        end
        if (I_IO_WR && hit_data) begin
            if (mode_ff == MODE_PASS && !serial_tx_busy_flag) begin
                tx_push = 1'b1;
            end
        end else if (I_IO_WR && hit_stat) begin
            case (I_IO_WDATA)
                CMD_RESET: begin
                    nxt_mode = MODE_RESET;
                    rx_flush = 1'b1;
                    nxt_ack  = (mode_ff != MODE_PASS);
                end
                CMD_PASS: begin
                    if (mode_ff == MODE_RESET) begin
                        nxt_mode = MODE_PASS;
                        rx_flush = 1'b1;
                        tx_flush = 1'b1;
                        nxt_ack  = 1'b1;
                    end
                end
                default: begin
                    nxt_mode = mode_ff;
                end
            endcase
        end
        rx_push = eng_rx_valid && (mode_ff == MODE_PASS) && (rx_cnt_ff != FIFO_FULL)
                  && !rx_flush;
        tx_pop  = eng_tx_ready && eng_enable && (tx_cnt_ff != '0);
        if (rx_flush) begin
            nxt_rx_wp  = '0;
            nxt_rx_rp  = '0;
            nxt_rx_cnt = '0;
        end else begin
            nxt_rx_wp  = rx_wp_ff + PTR_W'(rx_push);
            nxt_rx_rp  = rx_rp_ff + PTR_W'(rx_pop);
            nxt_rx_cnt = rx_cnt_ff + CNT_W'(rx_push) - CNT_W'(rx_pop);
        end
        if (tx_flush) begin
            nxt_tx_wp  = '0;
            nxt_tx_rp  = '0;
            nxt_tx_cnt = '0;
        end else begin
            nxt_tx_wp  = tx_wp_ff + PTR_W'(tx_push);
            nxt_tx_rp  = tx_rp_ff + PTR_W'(tx_pop);
            nxt_tx_cnt = tx_cnt_ff + CNT_W'(tx_push) - CNT_W'(tx_pop);
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            mode_ff      <= MODE_RESET;
            ack_ff       <= 1'b0;
            active_ff    <= 1'b0;
            base_hi_ff   <= BASE_HIGH_RESET;
            base_lo_ff   <= BASE_LOW_RESET;
            rdata_ff     <= 8'h00;
            rvalid_ff    <= 1'b0;
            cfg_rdata_ff <= 8'h00;
            rx_wp_ff     <= '0;
            rx_rp_ff     <= '0;
            rx_cnt_ff    <= '0;
            tx_wp_ff     <= '0;
            tx_rp_ff     <= '0;
            tx_cnt_ff    <= '0;
        end else begin
            mode_ff      <= nxt_mode;
            ack_ff       <= nxt_ack;
            active_ff    <= nxt_active;
            base_hi_ff   <= nxt_base_hi;
            base_lo_ff   <= nxt_base_lo;
            rdata_ff     <= nxt_rdata;
            rvalid_ff    <= nxt_rvalid;
            cfg_rdata_ff <= nxt_cfg_rdata;
            rx_wp_ff     <= nxt_rx_wp;
            rx_rp_ff     <= nxt_rx_rp;
            rx_cnt_ff    <= nxt_rx_cnt;
            tx_wp_ff     <= nxt_tx_wp;
            tx_rp_ff     <= nxt_tx_rp;
            tx_cnt_ff    <= nxt_tx_cnt;
        end
    end

    // fifo storage, no reset needed
    always_ff @(posedge I_CLK) begin
        if (rx_push) begin
            rx_mem[rx_wp_ff] <= eng_rx_data;
        end
        if (tx_push) begin
            tx_mem[tx_wp_ff] <= I_IO_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial engine
    midi_serial_engine #(
        .BIT_CYCLES_P (BIT_CYCLES_P)
    ) u_engine (
        .i_clk        (I_CLK),
        .i_rstn       (I_RSTN),
        .i_enable     (eng_enable),
        .i_tx_valid   (tx_cnt_ff != '0),
        .i_tx_data    (tx_mem[tx_rp_ff]),
        .o_tx_ready   (eng_tx_ready),
        .o_serial_out (O_SERIAL_OUT),
        .i_serial_in  (I_SERIAL_IN_LINE),
        .o_rx_valid   (eng_rx_valid),
        .o_rx_data    (eng_rx_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    logic stat_rd, data_rd, cmd_wr;
    assign stat_rd = I_IO_RD && hit_stat;
    assign data_rd = I_IO_RD && hit_data;
    assign cmd_wr  = I_IO_WR && hit_stat;

    a_status_flags: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        stat_rd |=> O_IO_RDATA[7] == $past(rx_buffer_empty_flag)
                    && O_IO_RDATA[6] == $past(serial_tx_busy_flag))
        else $error("status flags wrong");
    a_status_low_zero: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        stat_rd |=> O_IO_RDATA[5:0] == 6'h00 && O_IO_RVALID)
        else $error("status low bits not zero");
    a_irq_inactive: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        !active_ff |-> !O_IRQ)
        else $error("irq while inactive");
    a_irq_read_drop: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        data_rd && !ack_ff && rx_cnt_ff == 5'h01 && !rx_push && !I_IO_WR |=> !O_IRQ)
        else $error("irq stayed after last read");
    a_reset_ack: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        cmd_wr && I_IO_WDATA == CMD_RESET && mode_ff == MODE_RESET
        |=> ack_ff && rx_cnt_ff == 5'h00 && O_IRQ == active_ff)
        else $error("reset command not acknowledged");
    a_reset_in_pass: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        cmd_wr && I_IO_WDATA == CMD_RESET && mode_ff == MODE_PASS
        |=> !ack_ff && mode_ff == MODE_RESET && rx_cnt_ff == 5'h00)
        else $error("reset in pass-through mishandled");
    a_pass_enter: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        cmd_wr && I_IO_WDATA == CMD_PASS && mode_ff == MODE_RESET
        |=> mode_ff == MODE_PASS && ack_ff && tx_cnt_ff == 5'h00 && rx_cnt_ff == 5'h00)
        else $error("pass-through entry wrong");
    a_pass_repeat: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        cmd_wr && I_IO_WDATA == CMD_PASS && mode_ff == MODE_PASS && !I_IO_RD
        |=> mode_ff == MODE_PASS && $stable(ack_ff))
        else $error("repeat pass-through had an effect");
    a_reset_discard: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        mode_ff == MODE_RESET |-> rx_cnt_ff == 5'h00 && !tx_push && !eng_enable)
        else $error("data held in reset state");
    a_ack_first: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        data_rd && ack_ff |=> O_IO_RDATA == ACK_BYTE && O_IO_RVALID && !ack_ff)
        else $error("acknowledge not read first");

    c_pass_entered: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
        cmd_wr && I_IO_WDATA == CMD_PASS ##1 mode_ff == MODE_PASS);
    c_ack_read: cover property (@(posedge I_CLK) disable iff (!I_RSTN) data_rd && ack_ff);
    c_rx_byte: cover property (@(posedge I_CLK) disable iff (!I_RSTN) rx_push);
    c_tx_full: cover property (@(posedge I_CLK) disable iff (!I_RSTN) serial_tx_busy_flag);

endmodule

/* File: verif/host_bus_model.sv */
// host processor model: i/o and configuration strobes
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic        i_clk,
    input  wire logic [7:0]  i_rdata,
    input  wire logic        i_rvalid,
    output logic [15:0]      o_addr,
    output logic             o_wr,
    output logic             o_rd,
    output logic [7:0]       o_wdata,
    output logic             o_cfg_wr,
    output logic [7:0]       o_cfg_idx,
    output logic [7:0]       o_cfg_wdata,
    output logic             o_cfg_rd,
    input  wire logic [7:0]  i_cfg_rdata
);
    initial begin
        o_addr = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
        o_cfg_wr = 1'b0;
        o_cfg_idx = 8'h00;
        o_cfg_wdata = 8'h00;
        o_cfg_rd = 1'b0;
    end
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
        o_addr <= ~a;
    endtask
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        ok = i_rvalid;
        d = i_rdata;
    endtask
    task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge i_clk);
        o_cfg_idx <= i;
        o_cfg_wdata <= d;
        o_cfg_wr <= 1'b1;
        @(posedge i_clk);
        o_cfg_wr <= 1'b0;
    endtask
    task automatic cfg_rd(input logic [7:0] i, output logic [7:0] d);
        @(posedge i_clk);
        o_cfg_idx <= i;
        o_cfg_rd <= 1'b1;
        @(posedge i_clk);
        o_cfg_rd <= 1'b0;
        #1;
        d = i_cfg_rdata;
    endtask
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the host-facing midi port
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module testbench;
    import midi_host_port_pkg::*;
    localparam int          BITC = 16;
    localparam logic [15:0] BASE = 16'h0300;
    localparam logic [15:0] STA  = 16'h0301;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ser_in = 1'b1;
    logic [15:0] addr;
    logic        wr, rd, cfg_wr, cfg_rd, rvalid, irq, ser_out;
    logic [7:0]  wdata, rdata, cfg_idx, cfg_wdata, cfg_rdata, d;
    logic        ok;
    int          n_errors = 0;
    int          checked = 0;
    always #2.5 clk = ~clk;
    midi_host_port_uart #(.BIT_CYCLES_P(BITC)) midi_host_port_uart_i (
        .I_CLK(clk), .I_RSTN(rstn), .I_IO_ADDR(addr), .I_IO_WR(wr), .I_IO_RD(rd),
        .I_IO_WDATA(wdata), .O_IO_RDATA(rdata), .O_IO_RVALID(rvalid), .I_CFG_WR(cfg_wr),
        .I_CFG_RD(cfg_rd), .I_CFG_IDX(cfg_idx), .I_CFG_WDATA(cfg_wdata),
        .O_CFG_RDATA(cfg_rdata), .O_IRQ(irq), .I_SERIAL_IN_LINE(ser_in),
        .O_SERIAL_OUT(ser_out));
    host_bus_model host_bus_model_i (
        .i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr), .o_wr(wr),
        .o_rd(rd), .o_wdata(wdata), .o_cfg_wr(cfg_wr), .o_cfg_idx(cfg_idx),
        .o_cfg_wdata(cfg_wdata), .o_cfg_rd(cfg_rd), .i_cfg_rdata(cfg_rdata));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        host_bus_model_i.io_rd(a, d, ok);
        `CHK(ok, 1'b1)
        `CHK(d, exp)
    endtask
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            ser_in <= f[i];
            repeat (BITC - 1) @(posedge clk);
        end
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(irq, 1'b1)
        if (n == 400) stop_test();
    endtask
    task automatic get_tx(input logic [7:0] exp);
        int n;
        n = 0;
        while (ser_out !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n == 400) begin
            n_errors++;
            stop_test();
        end
        repeat (BITC / 2) @(posedge clk);
        `CHK(ser_out, 1'b0)
        for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(posedge clk);
            `CHK(ser_out, exp[i])
        end
        repeat (BITC) @(posedge clk);
        `CHK(ser_out, 1'b1)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        host_bus_model_i.io_rd(STA, d, ok);
        `CHK(ok, 1'b0)
        host_bus_model_i.cfg_wr(CFG_ACTIVATE_IDX, 8'h01);
        host_bus_model_i.cfg_wr(CFG_BASE_HIGH_IDX, 8'h03);
        host_bus_model_i.cfg_wr(CFG_BASE_LOW_IDX, 8'h00);
        host_bus_model_i.cfg_rd(CFG_BASE_HIGH_IDX, d);
        `CHK(d, 8'h03)
        rd_chk(STA, STATUS_RESET);
        host_bus_model_i.io_wr(BASE, 8'h55);
        send_byte(8'h11);
        repeat (40) @(posedge clk);
        #1;
        `CHK(ser_out, 1'b1)
        `CHK(irq, 1'b0)
        host_bus_model_i.io_wr(STA, 8'h12);
        rd_chk(STA, 8'h80);
        host_bus_model_i.io_wr(STA, CMD_RESET);
        wait_irq();
        rd_chk(STA, 8'h00);
        rd_chk(BASE, ACK_BYTE);
        `CHK(irq, 1'b0)
        host_bus_model_i.io_wr(STA, CMD_PASS);
        rd_chk(STA, 8'h00);
        rd_chk(BASE, ACK_BYTE);
        host_bus_model_i.io_wr(STA, CMD_PASS);
        rd_chk(STA, 8'h80);
        host_bus_model_i.io_wr(BASE, 8'ha5);
        get_tx(8'ha5);
        `CHK(irq, 1'b0)
        send_byte(8'h3c);
        send_byte(8'hc3);
        repeat (20) @(posedge clk);
        wait_irq();
        rd_chk(BASE, 8'h3c);
        `CHK(irq, 1'b1)
        rd_chk(BASE, 8'hc3);
        `CHK(irq, 1'b0)
        send_byte(8'h77);
        repeat (20) @(posedge clk);
        wait_irq();
        host_bus_model_i.io_wr(STA, CMD_RESET);
        rd_chk(STA, 8'h80);
        host_bus_model_i.io_wr(STA, CMD_RESET);
        wait_irq();
        host_bus_model_i.cfg_wr(CFG_ACTIVATE_IDX, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b0)
        host_bus_model_i.io_rd(BASE, d, ok);
        `CHK(ok, 1'b0)
        stop_test();
    end
endmodule
